// *** rtl/clsb_pkg.sv ***
// package: opcodes, widths and reset values for the logic/shift/branch execution slice
package clsb_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned FADDR_W   = 7;
    localparam int unsigned BIT_W     = 3;
    localparam int unsigned OPC_W     = 14;
    localparam int unsigned PC_W      = 15;
    localparam int unsigned BRA_OFF_W = 9;
    // ------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------
    localparam logic [5:0]  OPC_ADDWC     = 6'h3D;   // 11 1101 dfff ffff
    localparam logic [5:0]  OPC_ANDL      = 6'h39;   // 11 1001 kkkk kkkk
    localparam logic [5:0]  OPC_ANDF      = 6'h05;   // 00 0101 dfff ffff
    localparam logic [5:0]  OPC_ASR       = 6'h37;   // 11 0111 dfff ffff
    localparam logic [3:0]  OPC_BCLR      = 4'h4;    // 01 00bb bfff ffff
    localparam logic [4:0]  OPC_BRAL      = 5'h19;   // 11 001k kkkk kkkk
    localparam logic [13:0] OPC_BRACC     = 14'h000B; // 00 0000 0000 1011
    localparam logic [3:0]  ACC_BR_LOW_NIB = 4'hB;
    // ------------------------------------------------------------
    // reset values and destination select encodings
    // ------------------------------------------------------------
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [14:0] PC_RST        = 15'h0000;
    localparam logic        CARRY_RST     = 1'b0;
    localparam logic        ZERO_RST      = 1'b0;
    localparam logic        DEST_ACC      = 1'b0;
    localparam logic        DEST_FILE     = 1'b1;
    typedef enum logic [2:0] {
        CLSB_OP_NONE, CLSB_OP_ADDC, CLSB_OP_ANDL, CLSB_OP_ANDF,
        CLSB_OP_ASR, CLSB_OP_BCLR, CLSB_OP_BRAL, CLSB_OP_BRACC
    } clsb_op_t;
endpackage

// *** rtl/clsb_zero_det.sv ***
// zero detector for an operation result
`timescale 1ns/1ns
module clsb_zero_det #(
    parameter int unsigned W = 8
) (
    // operand
    input  wire logic [W-1:0] value,
    // result
    output wire logic         is_zero
);
    // reduction keeps the flag independent of the operation that made it
    assign is_zero = ~|value;
endmodule

// *** rtl/clsb_exec.sv ***
// execution slice: add with carry, and, arithmetic shift, bit clear, relative branches
`timescale 1ns/1ns
// How it works
// - add acc, carry, file; d picks target
// - and literal into acc, zero flag only
// - and file, d picks target, zero only
// - 7-bit file address, 3-bit bit index
// - shift right keeping bit 7 as sign
// - shifted-out bit to carry, zero updated
// - bit clear touches one bit, no flags
// - pc gets pc+1 plus signed 9-bit offset
// - literal branch: two cycles, no flags
// - acc branch: pc+1 plus unsigned acc
// - pc change adds a no-operation cycle
// - acc branch decoded from full opcode
module clsb_exec
    import clsb_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // instruction in
    input  wire logic                 instr_valid,
    input  wire logic [OPC_W-1:0]     instr,
    // file register read data for the decoded address
    input  wire logic [DATA_W-1:0]    file_rdata,
    // file register side
    output wire logic [FADDR_W-1:0]   file_addr,
    output logic                      file_we,
    output logic      [DATA_W-1:0]    file_wdata,
    // architectural state
    output logic      [DATA_W-1:0]    acc_q,
    output logic                      carry_q,
    output logic                      zero_q,
    output logic      [PC_W-1:0]      pc_q,
    // pipeline
    output wire logic                 busy,
    output logic                      unknown_op
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic        nop_q;
    wire logic   go       = instr_valid & ~nop_q;
    wire logic   dest     = instr[7];
    wire logic [2:0] bidx = instr[9:7];
    assign file_addr = instr[6:0];
    wire logic   is_bracc = (instr[13:12] == 2'b00) && (instr == OPC_BRACC)
                           && (instr[3:0] == ACC_BR_LOW_NIB);
    wire logic   is_bral = instr[13:9] == OPC_BRAL;
    clsb_op_t op;
    assign op = is_bracc                     ? CLSB_OP_BRACC :
                is_bral                      ? CLSB_OP_BRAL :
                (instr[13:8] == OPC_ADDWC)   ? CLSB_OP_ADDC :
                (instr[13:8] == OPC_ANDL)    ? CLSB_OP_ANDL :
                (instr[13:8] == OPC_ANDF)    ? CLSB_OP_ANDF :
                (instr[13:8] == OPC_ASR)     ? CLSB_OP_ASR  :
                (instr[13:10] == OPC_BCLR)   ? CLSB_OP_BCLR : CLSB_OP_NONE;
    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    // nine bits so the carry out of the sum is kept
    wire logic [8:0] sum9   = {1'b0, acc_q} + {1'b0, file_rdata} + {8'h00, carry_q};
    wire logic [7:0] and_l  = acc_q & instr[7:0];
    wire logic [7:0] and_f  = acc_q & file_rdata;
    wire logic [7:0] asr_r  = {file_rdata[7], file_rdata[7:1]};
    wire logic [7:0] bmask  = ~(8'h01 << bidx);
    wire logic [7:0] bclr_r = file_rdata & bmask;
    wire logic [PC_W-1:0] pc_inc  = pc_q + 15'h0001;
    wire logic [PC_W-1:0] off_s   = {{(PC_W-BRA_OFF_W){instr[8]}}, instr[8:0]};
    wire logic [PC_W-1:0] off_acc = {7'h00, acc_q};
    logic [7:0] res;
    always_comb begin
        unique case (op)
            CLSB_OP_ADDC: res = sum9[7:0];
            CLSB_OP_ANDL: res = and_l;
            CLSB_OP_ANDF: res = and_f;
            CLSB_OP_ASR:  res = asr_r;
            CLSB_OP_BCLR: res = bclr_r;
            default:      res = 8'h00;
        endcase
    end
    logic res_zero;
    clsb_zero_det #(.W(DATA_W)) clsb_zero_det_i (
        .value   (res),
        .is_zero (res_zero)
    );
    wire logic to_file = go && ((op == CLSB_OP_BCLR) ||
        (dest == DEST_FILE && (op == CLSB_OP_ADDC || op == CLSB_OP_ANDF
                               || op == CLSB_OP_ASR)));
    wire logic to_acc  = go && ((op == CLSB_OP_ANDL) ||
        (dest == DEST_ACC && (op == CLSB_OP_ADDC || op == CLSB_OP_ANDF
                              || op == CLSB_OP_ASR)));
    wire logic zero_upd  = go && (op == CLSB_OP_ADDC || op == CLSB_OP_ANDL
                                  || op == CLSB_OP_ANDF || op == CLSB_OP_ASR);
    wire logic carry_upd = go && (op == CLSB_OP_ADDC || op == CLSB_OP_ASR);
    wire logic carry_d   = (op == CLSB_OP_ASR) ? file_rdata[0] : sum9[8];
    wire logic is_branch = go && (op == CLSB_OP_BRAL || op == CLSB_OP_BRACC);
    wire logic [PC_W-1:0] pc_d = (op == CLSB_OP_BRACC) ? pc_inc + off_acc
                                                     : pc_inc + off_s;
    assign busy = nop_q;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // architectural registers; branches leave flags alone
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_q   <= ACC_RST;
            carry_q <= CARRY_RST;
            zero_q  <= ZERO_RST;
        end else begin
            if (to_acc)    acc_q   <= res;
            if (carry_upd) carry_q <= carry_d;
            if (zero_upd)  zero_q  <= res_zero;
        end
    end
    // program counter and the flush cycle after a taken branch
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_q  <= PC_RST;
            nop_q <= 1'b0;
        end else begin
            nop_q <= is_branch;
            if (is_branch)     pc_q <= pc_d;
            else if (go)       pc_q <= pc_inc;
        end
    end
    // write port registered so data output comes from flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            file_we    <= 1'b0;
            file_wdata <= 8'h00;
            unknown_op <= 1'b0;
        end else begin
            file_we    <= to_file;
            file_wdata <= res;
            unknown_op <= go && (op == CLSB_OP_NONE);
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_branch_go;
        go && (op == CLSB_OP_BRAL || op == CLSB_OP_BRACC);
    endsequence
    sequence s_flush;
        busy ##1 !busy;
    endsequence
    AST_ADDC_ACC: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ADDC && dest == DEST_ACC |=>
        acc_q == $past(sum9[7:0]) && carry_q == $past(sum9[8]))
        else $error("add with carry result wrong");
    AST_ANDL: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ANDL |=> acc_q == $past(and_l) && $stable(carry_q))
        else $error("and literal wrong");
    AST_ANDF_FILE: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ANDF && dest == DEST_FILE |=>
        file_we && file_wdata == $past(and_f) && $stable(acc_q))
        else $error("and file write wrong");
    AST_ASR: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ASR && dest == DEST_ACC |=>
        acc_q[7] == $past(file_rdata[7]) && acc_q[6:0] == $past(file_rdata[7:1]))
        else $error("shift result wrong");
    AST_ASR_FLAGS: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ASR |=> carry_q == $past(file_rdata[0])
        && zero_q == ($past(asr_r) == 8'h00))
        else $error("shift flags wrong");
    AST_BCLR: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_BCLR |=> file_we && file_wdata[$past(bidx)] == 1'b0
        && $stable(zero_q) && $stable(carry_q))
        else $error("bit clear wrong");
    AST_BRAL_PC: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_BRAL |=> pc_q == $past(pc_q) + 15'h0001 + $past(off_s))
        else $error("literal branch target wrong");
    AST_BRANCH_TWO: assert property (@(posedge mclk) disable iff (rst)
        s_branch_go |=> s_flush ##0 ($stable(zero_q) && $stable(carry_q)))
        else $error("branch not two cycles");
    AST_BRACC_PC: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_BRACC |=> pc_q == $past(pc_q) + 15'h0001 + {7'h00, $past(acc_q)})
        else $error("acc branch target wrong");
    AST_FLUSH_NOP: assert property (@(posedge mclk) disable iff (rst)
        busy |-> !go ##1 ($stable(acc_q) && !file_we))
        else $error("flush cycle did work");
    AST_ZERO: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ANDF |=> zero_q == ($past(and_f) == 8'h00))
        else $error("zero flag wrong");
    // destination and write-port checks for the file- and acc-targeting forms
    AST_ADDC_FILE: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ADDC && dest == DEST_FILE |=>
        file_we && file_wdata == $past(sum9[7:0]) && $stable(acc_q))
        else $error("add with carry write wrong");
    AST_ANDL_ZERO: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ANDL |=>
        zero_q == ($past(and_l) == 8'h00) && !file_we)
        else $error("and literal flags wrong");
    AST_ANDF_ACC: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ANDF && dest == DEST_ACC |=>
        acc_q == $past(and_f) && !file_we && $stable(carry_q))
        else $error("and file to acc wrong");
    AST_ASR_FILE: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_ASR && dest == DEST_FILE |=> file_we && $stable(acc_q)
        && file_wdata == {$past(file_rdata[7]), $past(file_rdata[7:1])})
        else $error("shift write wrong");
    // bit clear must leave the seven other bits exactly as they were read
    AST_BCLR_KEEP: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_BCLR |=> $stable(acc_q) &&
        (file_wdata | (8'h01 << $past(bidx))) == ($past(file_rdata) | (8'h01 << $past(bidx))))
        else $error("bit clear disturbed other bits");
    AST_BRACC_FLAGS: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_BRACC |=> $stable(acc_q) && $stable(zero_q)
        && $stable(carry_q) && !file_we)
        else $error("acc branch touched state");
    // every non-branch form, foreign ones too, steps pc by one and never flushes
    AST_STEP_PC: assert property (@(posedge mclk) disable iff (rst)
        go && !(op == CLSB_OP_BRAL || op == CLSB_OP_BRACC) |=>
        pc_q == $past(pc_q) + 15'h0001 && !busy)
        else $error("single cycle step wrong");
    AST_UNKNOWN: assert property (@(posedge mclk) disable iff (rst)
        go && op == CLSB_OP_NONE |=> unknown_op && !file_we && $stable(acc_q)
        && $stable(zero_q) && $stable(carry_q))
        else $error("foreign opcode changed state");
    // no disable here: this one watches the reset itself
    AST_RESET_STATE: assert property (@(posedge mclk)
        rst |=> acc_q == ACC_RST && carry_q == CARRY_RST && zero_q == ZERO_RST
        && pc_q == PC_RST && !busy && !file_we && !unknown_op)
        else $error("state not cleared by reset");
endmodule

// *** verif/clsb_exec_tb_top.sv ***
// self-checking testbench for the logic, shift and branch execution slice
`timescale 1ns/1ns
module clsb_exec_tb_top;
    import clsb_pkg::*;
    // ------------------------------------------------------------
    // design connections and expected state
    // ------------------------------------------------------------
    logic               mclk;
    logic               rst;
    logic               instr_valid;
    logic [OPC_W-1:0]   instr;
    logic [DATA_W-1:0]  file_rdata;
    wire  [FADDR_W-1:0] file_addr;
    wire                file_we;
    wire  [DATA_W-1:0]  file_wdata;
    wire  [DATA_W-1:0]  acc_q;
    wire                carry_q;
    wire                zero_q;
    wire  [PC_W-1:0]    pc_q;
    wire                busy;
    wire                unknown_op;
    int                 n_fail;
    int                 n_checks;
    logic [DATA_W-1:0]  e_acc;
    logic               e_c;
    logic               e_z;
    logic [PC_W-1:0]    e_pc;

    clsb_exec clsb_exec_i (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .acc_q(acc_q), .carry_q(carry_q), .zero_q(zero_q),
        .pc_q(pc_q), .busy(busy), .unknown_op(unknown_op));

    // free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // compare, issue and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single-cycle op; file data is presented as a combinational read
    task automatic op(input logic [13:0] i, input logic [7:0] fd, input logic we,
                      input logic [7:0] wd);
        instr_valid = 1'b1;
        instr = i;
        file_rdata = fd;
        #1 chk(16'(file_addr), 16'(i[6:0]));
        @(negedge mclk);
        e_pc = e_pc + 15'h0001;
        chk(16'(acc_q), 16'(e_acc));
        chk(16'(carry_q), 16'(e_c));
        chk(16'(zero_q), 16'(e_z));
        chk(16'(pc_q), 16'(e_pc));
        chk(16'(file_we), 16'(we));
        if (we) chk(16'(file_wdata), 16'(wd));
    endtask

    // branch, then an op offered in the flush cycle that must be dropped
    task automatic br(input logic [13:0] i, input logic [14:0] off);
        instr_valid = 1'b1;
        instr = i;
        @(negedge mclk);
        e_pc = e_pc + 15'h0001 + off;
        chk(16'(pc_q), 16'(e_pc));
        chk(16'(busy), 16'h0001);
        chk(16'({acc_q, carry_q, zero_q}), 16'({e_acc, e_c, e_z}));
        instr = {OPC_ANDL, 8'h00};
        @(negedge mclk);
        chk(16'(busy), 16'h0000);
        chk(16'(pc_q), 16'(e_pc));
        chk(16'(acc_q), 16'(e_acc));
    endtask

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under a hundred cycles
    initial begin
        #20000;
        n_fail++;
        test_done();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_arith_logic();
        e_acc = 8'hA5;
        op({OPC_ADDWC, 1'b0, 7'h7F}, 8'hA5, 1'b0, 8'h00);
        e_c = 1'b1;
        e_z = 1'b1;
        op({OPC_ADDWC, 1'b1, 7'h00}, 8'h5B, 1'b1, 8'h00);
        e_acc = 8'h05;
        e_z = 1'b0;
        op({OPC_ANDL, 8'h0F}, 8'hFF, 1'b0, 8'h00);
        e_z = 1'b1;
        op({OPC_ANDF, 1'b1, 7'h33}, 8'hF0, 1'b1, 8'h00);
        e_z = 1'b0;
        op({OPC_ANDF, 1'b0, 7'h01}, 8'h07, 1'b0, 8'h00);
    endtask

    task automatic t_shift_clear();
        e_acc = 8'hC0;
        op({OPC_ASR, 1'b0, 7'h40}, 8'h81, 1'b0, 8'h00);
        e_z = 1'b1;
        op({OPC_ASR, 1'b1, 7'h41}, 8'h01, 1'b1, 8'h00);
        e_c = 1'b0;
        e_z = 1'b0;
        op({OPC_ASR, 1'b1, 7'h42}, 8'h02, 1'b1, 8'h01);
        for (int b = 0; b < 8; b++) begin
            op({OPC_BCLR, 3'(b), 7'h2A}, 8'hFF, 1'b1, ~(8'h01 << b));
        end
    endtask

    task automatic t_branch();
        br({OPC_BRAL, 9'h0FF}, 15'h00FF);
        br({OPC_BRAL, 9'h100}, 15'h7F00);
        br(OPC_BRACC, {7'h00, e_acc});
        op(14'h0000, 8'h00, 1'b0, 8'h00);
        chk(16'(unknown_op), 16'h0001);
    endtask

    // mid-run reset while a flush is pending, then an instruction at the first edge
    task automatic t_reset();
        instr = {OPC_BRAL, 9'h004};
        @(negedge mclk);
        chk(16'(busy), 16'h0001);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        chk(16'({acc_q, carry_q, zero_q}), 16'({ACC_RST, CARRY_RST, ZERO_RST}));
        chk(16'({busy, file_we, unknown_op}), 16'h0000);
        chk(16'(pc_q), 16'(PC_RST));
        e_acc = ACC_RST;
        e_c = CARRY_RST;
        e_z = 1'b1;
        e_pc = PC_RST;
        op({OPC_ANDL, 8'hFF}, 8'h00, 1'b0, 8'h00);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        file_rdata = '0;
        n_fail = 0;
        n_checks = 0;
        e_acc = ACC_RST;
        e_c = 1'b0;
        e_z = 1'b0;
        e_pc = PC_RST;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        chk(16'({acc_q, carry_q, zero_q}), 16'({ACC_RST, CARRY_RST, ZERO_RST}));
        chk(16'({busy, file_we, unknown_op}), 16'h0000);
        chk(16'(pc_q), 16'(PC_RST));
        t_arith_logic();
        t_shift_clear();
        t_branch();
        t_reset();
        test_done();
    end
endmodule
